// File: hw/ebr_array.sv
`timescale 1ns/10ps
`default_nettype none
module ebrp_array
	import ebrp_pkg::*;
#(
	parameter int ADDR_W = EBRP_ADDR_W,
	parameter int DATA_W = EBRP_DATA_W,
	parameter int DEPTH = EBRP_DEPTH
) (
	input wire logic clock_i,
	input wire logic [1:0] we_i,
	input wire logic [1:0][ADDR_W-1:0] addr_i,
	input wire logic [1:0][DATA_W-1:0] wdata_i,
	output logic [1:0][DATA_W-1:0] rdata_o
);

	// no reset: contents survive every clear
	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// read sees the word before this edge's write, which gives read-before-write
	always_comb begin
		rdata_o[0] = mem[addr_i[0]];
		rdata_o[1] = mem[addr_i[1]];
	end

	// same-address collision: port b is applied last and wins
	always_ff @(posedge clock_i) begin
		if (we_i[0]) begin
			mem[addr_i[0]] <= wdata_i[0];
		end
		if (we_i[1]) begin
			mem[addr_i[1]] <= wdata_i[1];
		end
	end

endmodule
`default_nettype wire

// File: hw/ebr_pkg.sv
package ebrp_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int EBRP_ADDR_W = 9;
	localparam int EBRP_DATA_W = 36;
	localparam int EBRP_DEPTH = 512;
	localparam int EBRP_APB_AW = 12;
	// read-before-write exists only for the x9, x18 and x36 organisations
	localparam logic EBRP_RBW_OK = (EBRP_DATA_W == 9) || (EBRP_DATA_W == 18)
		|| (EBRP_DATA_W == 36);

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [EBRP_APB_AW-1:0] EBRP_CFG_OFS = 12'h000;
	localparam logic [EBRP_APB_AW-1:0] EBRP_STAT_OFS = 12'h004;
	localparam int EBRP_CFG_MODE_LSB = 0;
	localparam int EBRP_CFG_OREG_BIT = 2;
	localparam int EBRP_CFG_ASYNC_BIT = 3;
	localparam int EBRP_STAT_RBW_BIT = 0;
	localparam int EBRP_STAT_CLR_LSB = 1;
	localparam logic [3:0] EBRP_CFG_RST = 4'h0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		EBRP_WM_NORMAL = 2'h0,
		EBRP_WM_THRU = 2'h1,
		EBRP_WM_RBW = 2'h2
	} ebrp_wmode_type;

	typedef struct packed {
		logic clr_async;
		logic oreg;
		ebrp_wmode_type mode;
	} ebrp_cfg_type;

	typedef struct packed {
		logic en;
		logic we;
		logic [EBRP_ADDR_W-1:0] addr;
		logic [EBRP_DATA_W-1:0] wdata;
	} ebrp_req_type;

	typedef struct packed {
		ebrp_req_type req;
		logic clr_q;
		logic [EBRP_DATA_W-1:0] latch;
		logic [EBRP_DATA_W-1:0] dout;
		logic cleared;
	} ebrp_port_type;

	typedef struct packed {
		ebrp_cfg_type cfg;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		ebrp_port_type [1:0] port;
	} ebrp_state_type;

endpackage

// File: hw/ebr_ram.sv
// Functional notes
// RQ1: each port's address and write data are registered at the array input before use.
// RQ2: an optional output register stage follows the latch; off, the latch drives the output.
// RQ3: in normal mode the output shows stored data only after a read cycle on that port.
// RQ4: in normal mode a write leaves the port output at its previous value.
// RQ5: in write-through mode a write puts the incoming data on the same port's output.
// RQ6: in read-before-write mode a write shows the old word; only for 9, 18 and 36 bit widths.
// RQ7: the port output clear acts either at once or in step with the port pipeline.
// RQ8: each port has its own clear input that clears only that port's output.
// RQ9: the active-low global clear empties both port outputs regardless of port clears.
// RQ10: a cleared output reads zero until the next update; no clear touches the array.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ebrp_ram
	import ebrp_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [EBRP_APB_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic pslverr_o,
	output logic [31:0] prdata_o,
	input wire ebrp_req_type port_a_req_i,
	input wire ebrp_req_type port_b_req_i,
	input wire logic port_a_output_clear_i,
	input wire logic port_b_output_clear_i,
	input wire logic global_clear_n_i,
	output logic [EBRP_DATA_W-1:0] port_a_dout_o,
	output logic [EBRP_DATA_W-1:0] port_b_dout_o
);

	// ----------------------------------------
	// state and wiring
	// ----------------------------------------
	ebrp_state_type st_r;
	ebrp_state_type st_nxt;
	ebrp_req_type [1:0] req_in;
	logic [1:0] clr_in;
	logic [1:0] clr_now;
	logic [1:0] quiet;
	logic [1:0] arr_we;
	logic [1:0][EBRP_ADDR_W-1:0] arr_addr;
	logic [1:0][EBRP_DATA_W-1:0] arr_wdata;
	logic [1:0][EBRP_DATA_W-1:0] rdata;
	logic hit_cfg;
	logic hit_stat;
	logic [31:0] rd_word;

	assign req_in[0] = port_a_req_i;
	assign req_in[1] = port_b_req_i;
	assign clr_in[0] = port_a_output_clear_i;
	assign clr_in[1] = port_b_output_clear_i;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			// async: clear taken at the next edge; sync: rides the input stage
			assign clr_now[p] = st_r.cfg.clr_async ? clr_in[p] : st_r.port[p].clr_q; // RQ7 RQ8
			assign quiet[p] = !clr_now[p] && global_clear_n_i;
			assign arr_we[p] = st_r.port[p].req.en && st_r.port[p].req.we; // RQ1
			assign arr_addr[p] = st_r.port[p].req.addr;
			assign arr_wdata[p] = st_r.port[p].req.wdata;
		end
	endgenerate

	ebrp_array u_array (
		.clock_i(clock_i),
		.we_i(arr_we),
		.addr_i(arr_addr),
		.wdata_i(arr_wdata),
		.rdata_o(rdata)
	);

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	assign hit_cfg = (paddr_i == EBRP_CFG_OFS);
	assign hit_stat = (paddr_i == EBRP_STAT_OFS);

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_cfg) begin
			rd_word[EBRP_CFG_MODE_LSB +: 2] = st_r.cfg.mode;
			rd_word[EBRP_CFG_OREG_BIT] = st_r.cfg.oreg;
			rd_word[EBRP_CFG_ASYNC_BIT] = st_r.cfg.clr_async;
		end else if (hit_stat) begin
			rd_word[EBRP_STAT_RBW_BIT] = EBRP_RBW_OK;
			rd_word[EBRP_STAT_CLR_LSB] = st_r.port[0].cleared;
			rd_word[EBRP_STAT_CLR_LSB + 1] = st_r.port[1].cleared;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		// zero wait states: answer prepared during setup
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		if (psel_i && !penable_i) begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = !(hit_cfg || hit_stat);
			st_nxt.prdata = rd_word;
		end
		if (psel_i && penable_i && st_r.pready && pwrite_i && hit_cfg) begin
			st_nxt.cfg.mode = ebrp_wmode_type'(pwdata_i[EBRP_CFG_MODE_LSB +: 2]);
			st_nxt.cfg.oreg = pwdata_i[EBRP_CFG_OREG_BIT];
			st_nxt.cfg.clr_async = pwdata_i[EBRP_CFG_ASYNC_BIT];
		end
		for (int i = 0; i < 2; i++) begin
			st_nxt.port[i].req = req_in[i]; // RQ1
			st_nxt.port[i].clr_q = clr_in[i];
			if (st_r.port[i].req.en) begin
				if (!st_r.port[i].req.we) begin
					st_nxt.port[i].latch = rdata[i]; // RQ3
					st_nxt.port[i].cleared = 1'b0;
				end else begin
					unique case (st_r.cfg.mode)
						EBRP_WM_NORMAL: begin
							st_nxt.port[i].latch = st_r.port[i].latch; // RQ4
						end
						EBRP_WM_THRU: begin
							st_nxt.port[i].latch = st_r.port[i].req.wdata; // RQ5
							st_nxt.port[i].cleared = 1'b0;
						end
						EBRP_WM_RBW: begin
							// widths without the mode fall back to normal behaviour
							if (EBRP_RBW_OK) begin
								st_nxt.port[i].latch = rdata[i]; // RQ6
								st_nxt.port[i].cleared = 1'b0;
							end
						end
						default: begin
							st_nxt.port[i].latch = st_r.port[i].latch;
						end
					endcase
				end
			end
			st_nxt.port[i].dout = st_r.cfg.oreg ? st_r.port[i].latch
				: st_nxt.port[i].latch; // RQ2
			if (clr_now[i] || !global_clear_n_i) begin
				st_nxt.port[i].latch = '0; // RQ8 RQ9 RQ10
				st_nxt.port[i].dout = '0;
				st_nxt.port[i].cleared = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st_r <= '0;
			st_r.cfg <= ebrp_cfg_type'(EBRP_CFG_RST);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready_o = st_r.pready;
	assign pslverr_o = st_r.pslverr;
	assign prdata_o = st_r.prdata;
	assign port_a_dout_o = st_r.port[0].dout;
	assign port_b_dout_o = st_r.port[1].dout;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("apb setup not answered next cycle");

	generate
		for (p = 0; p < 2; p++) begin : g_chk
			sequence s_read_in;
				req_in[p].en && !req_in[p].we;
			endsequence
			sequence s_write_in(ebrp_wmode_type m);
				req_in[p].en && req_in[p].we && st_r.cfg.mode == m;
			endsequence

			read_capture_a: assert property (s_read_in // RQ1 RQ3
				##1 (quiet[p] && st_r.port[p].req.en)
				|=> st_r.port[p].latch == $past(rdata[p]))
				else $error("read data not latched");
			normal_hold_a: assert property (s_write_in(EBRP_WM_NORMAL) // RQ4
				##1 (quiet[p] && st_r.cfg.mode == EBRP_WM_NORMAL) |=> $stable(st_r.port[p].latch))
				else $error("normal write changed output");
			write_thru_a: assert property (s_write_in(EBRP_WM_THRU) // RQ5
				##1 (quiet[p] && st_r.cfg.mode == EBRP_WM_THRU)
				|=> st_r.port[p].latch == $past(req_in[p].wdata, 2))
				else $error("write-through data missing");
			rbw_old_a: assert property (s_write_in(EBRP_WM_RBW) // RQ6
				##1 (quiet[p] && st_r.cfg.mode == EBRP_WM_RBW && EBRP_RBW_OK)
				|=> st_r.port[p].latch == $past(rdata[p]))
				else $error("old word not shown on write");
			oreg_stage_a: assert property (st_r.cfg.oreg && quiet[p] // RQ2
				|=> st_r.port[p].dout == $past(st_r.port[p].latch))
				else $error("output register stage wrong");
			async_clear_a: assert property (st_r.cfg.clr_async && clr_in[p] // RQ7 RQ8
				|=> st_r.port[p].dout == '0 && st_r.port[p].latch == '0)
				else $error("async clear missed");
			sync_clear_a: assert property (!st_r.cfg.clr_async && clr_in[p] // RQ7
				##1 !st_r.cfg.clr_async |=> st_r.port[p].latch == '0)
				else $error("sync clear missed");
			global_clear_a: assert property (!global_clear_n_i // RQ9
				|=> st_r.port[p].dout == '0 && st_r.port[p].latch == '0)
				else $error("global clear missed");
			cleared_zero_a: assert property (st_r.port[p].cleared // RQ10
				|-> st_r.port[p].latch == '0 && st_r.port[p].dout == '0)
				else $error("cleared output not zero");
			// checked from both sides, so whichever port the bench clears in async mode arms it
			clear_isolate_a: assert property (st_r.cfg.clr_async && clr_in[p] // RQ8
				&& !clr_in[1-p] && global_clear_n_i && !st_r.port[1-p].req.en
				&& !st_r.cfg.oreg |=> $stable(st_r.port[1-p].dout))
				else $error("one port clear disturbed the other port");
		end
	endgenerate

endmodule
`default_nettype wire

// File: test/ebr_ram_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ebrp_ram_tb
	import ebrp_pkg::*;
;
	typedef struct packed {
		logic [1:0] m;
		logic we;
		logic [8:0] a;
		logic [35:0] d;
		logic [35:0] e;
	} ebrp_row_type;
	localparam logic [35:0] VA = 36'h1_2345_6789;
	localparam logic [35:0] VB = 36'hA_BCDE_F012;
	localparam logic [35:0] VC = 36'h5_5AA5_5AA5;
	localparam logic [35:0] VD = 36'hF_0F0F_0F0F;
	logic clock_i, reset_i, psel_i, penable_i, pwrite_i, glob_n, pready_o, pslverr_o, err;
	logic clr_a, clr_b;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [35:0] dout_a, dout_b;
	ebrp_req_type req_a, req_b;
	ebrp_row_type rows [8];
	int failures = 0;
	int total_checks = 0;

	ebrp_user_model pa (.clock_i(clock_i), .req_o(req_a), .clear_o(clr_a));
	ebrp_user_model pb (.clock_i(clock_i), .req_o(req_b), .clear_o(clr_b));
	ebrp_ram uut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.prdata_o(prdata_o), .port_a_req_i(req_a), .port_b_req_i(req_b),
		.port_a_output_clear_i(clr_a), .port_b_output_clear_i(clr_b),
		.global_clear_n_i(glob_n), .port_a_dout_o(dout_a), .port_b_dout_o(dout_b));

	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n = 0;
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (pready_o !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask
	// returns just after the edge where the output shows the result with no output stage
	task automatic acc(input logic b, input logic we, input logic [8:0] a, input logic [35:0] d);
		if (b) pb.access(we, a, d);
		else pa.access(we, a, d);
		@(posedge clock_i);
		#1;
	endtask

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		glob_n = 1'b1;
		reset_i = 1'b1;
		rows = '{
			'{2'h0, 1'b1, 9'h005, VA, 36'h0},
			'{2'h0, 1'b0, 9'h005, 36'h0, VA},
			'{2'h1, 1'b1, 9'h006, VB, VB},
			'{2'h0, 1'b1, 9'h005, VC, VB},
			'{2'h2, 1'b1, 9'h005, VD, VC},
			'{2'h3, 1'b1, 9'h007, VA, VC},
			'{2'h0, 1'b0, 9'h007, 36'h0, VA},
			'{2'h0, 1'b0, 9'h006, 36'h0, VB}
		};
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		foreach (rows[i]) begin
			apb(1'b1, 12'h000, {30'h0, rows[i].m});
			acc(1'b0, rows[i].we, rows[i].a, rows[i].d);
			check(dout_a, rows[i].e);
		end
		// sync clear lags one stage; the other port must not move
		acc(1'b1, 1'b0, 9'h006, 36'h0);
		pa.clear_pulse();
		#1 check(dout_a, VB);
		@(posedge clock_i);
		#1 check(dout_a, 36'h0);
		check(dout_b, VB);
		apb(1'b0, 12'h004, 32'h0);
		check({33'h0, rd[2:0]}, 36'h3);
		apb(1'b1, 12'h000, 32'h8);
		acc(1'b0, 1'b0, 9'h005, 36'h0);
		check(dout_a, VD);
		pb.clear_pulse();
		#1 check(dout_b, 36'h0);
		check(dout_a, VD);
		acc(1'b1, 1'b0, 9'h006, 36'h0);
		@(posedge clock_i);
		glob_n <= 1'b0;
		@(posedge clock_i);
		glob_n <= 1'b1;
		#1 check(dout_a | dout_b, 36'h0);
		apb(1'b1, 12'h000, 32'h4);
		acc(1'b0, 1'b0, 9'h005, 36'h0);
		check(dout_a, 36'h0);
		@(posedge clock_i);
		#1 check(dout_a, VD);
		apb(1'b0, 12'h000, 32'h0);
		check({4'h0, rd}, 36'h4);
		apb(1'b0, 12'h008, 32'h0);
		check({35'h0, err}, 36'h1);
		check({4'h0, rd}, 36'h0);
		// mid-run reset: outputs and config drop to zero, the array keeps its words
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		#1 check(dout_a | dout_b, 36'h0);
		apb(1'b0, 12'h000, 32'h0);
		check({4'h0, rd}, 36'h0);
		acc(1'b0, 1'b0, 9'h005, 36'h0);
		check(dout_a, VD);
		print_verdict();
	end
endmodule
`default_nettype wire

// File: test/ebr_user_model.sv
`timescale 1ns/10ps
`default_nettype none
module ebrp_user_model
	import ebrp_pkg::*;
(
	input wire logic clock_i,
	output var ebrp_req_type req_o,
	output var logic clear_o
);
	initial begin
		req_o = '0;
		clear_o = 1'b0;
	end
	// request held over exactly one sampling edge
	task automatic access(input logic we, input logic [EBRP_ADDR_W-1:0] a,
		input logic [EBRP_DATA_W-1:0] d);
		@(posedge clock_i);
		req_o <= '{en: 1'b1, we: we, addr: a, wdata: d};
		@(posedge clock_i);
		// idle lines carry inverted junk so a stray capture shows
		req_o <= '{en: 1'b0, we: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic clear_pulse();
		@(posedge clock_i);
		clear_o <= 1'b1;
		@(posedge clock_i);
		clear_o <= 1'b0;
	endtask
endmodule
`default_nettype wire
